// >>> logic/rxc_pkg.sv
// Constants, types and register map of the receiver mode control block
package rxc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int AUTO_RX_DELAY_NS = 30_000_000;
  localparam int CFG_ENTRY_DELAY_NS = 1_500_000;
  localparam int CFG_TIMEOUT_NS = 20_000_000;
  localparam int AUTO_RX_CYC = (AUTO_RX_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_ENTRY_CYC = (CFG_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_TIMEOUT_CYC = (CFG_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 22;

  // ----------------------------------------------------------------
  // Register map: index 0 is the lowest offset
  // ----------------------------------------------------------------
  localparam int NUM_REGS = 12;
  localparam int IDX_OM = 1;
  localparam int IDX_TS1 = 2;
  localparam int IDX_SX1 = 3;
  localparam int IDX_SX2 = 4;
  localparam int IDX_SX3 = 5;
  localparam int IDX_SX4 = 6;
  localparam int IDX_TS3 = 8;
  localparam int IDX_TS4 = 9;
  localparam int IDX_EXIT = 11;
  localparam logic [11:0][7:0] REG_ADDR = {8'h42, 8'h39, 8'h19, 8'h18,
    8'h17, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10, 8'h05};
  localparam logic [11:0][7:0] REG_RST = {8'h00, 8'hc2, 8'h8d, 8'h74,
    8'h7f, 8'h65, 8'hf3, 8'hb7, 8'h2b, 8'hb5, 8'h00, 8'h07};
  localparam logic [11:0][7:0] REG_WMASK = {8'h01, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h0f, 8'hff, 8'hff, 8'h7f, 8'hff, 8'h60, 8'hff};
  localparam int EXIT_BIT = 0;
  localparam int BAND_LSB = 5;
  localparam int FRAC_HI_W = 4;

  // Band field codes and band strap preset values
  localparam logic [1:0] BAND_315 = 2'h0;
  localparam logic [1:0] BAND_433 = 2'h1;
  localparam logic [1:0] BAND_868 = 2'h3;
  localparam logic [6:0] INT_315 = 7'h3e;
  localparam logic [19:0] FRAC_315 = 20'hf_5c28;
  localparam logic [7:0] TS1_868 = 8'hb6;
  localparam logic [7:0] TS3_868 = 8'hd0;
  localparam logic [7:0] TS4_868 = 8'h91;

  // Band strap pin as sensed: grounded, floating, tied to supply
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_VDD = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF = 4'b0001,
    MODE_SLEEP = 4'b0010,
    MODE_RX = 4'b0100,
    MODE_CFG = 4'b1000
  } rxc_mode_t;

  typedef enum logic [4:0] {
    I2C_IDLE = 5'b00001,
    I2C_ADDR = 5'b00010,
    I2C_PTR = 5'b00100,
    I2C_WR = 5'b01000,
    I2C_RD = 5'b10000
  } rxc_i2c_t;

  typedef struct packed {
    logic [1:0] band_sel;
    logic [6:0] int_code;
    logic [19:0] frac_code;
    logic [5:0][7:0] tuning;
  } rxc_cfg_t;

endpackage : rxc_pkg

// >>> logic/rxc_top.sv
// Mode sequencer and I2C configuration slave of the OOK receiver
`timescale 1ns/1ps
module rxc_top #(
  parameter int AUTO_RX_CYCLES = rxc_pkg::AUTO_RX_CYC,
  parameter int CFG_ENTRY_CYCLES = rxc_pkg::CFG_ENTRY_CYC,
  parameter int CFG_TIMEOUT_CYCLES = rxc_pkg::CFG_TIMEOUT_CYC,
  parameter logic FOUR_BAND = 1'b1,
  parameter logic [6:0] SLAVE_ADDR = 7'h50,
  parameter logic [6:0] INT_868 = 7'h36,
  parameter logic [19:0] FRAC_868 = 20'h0_0000
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] band_strap,
  input wire logic demod_data,
  output rxc_pkg::rxc_mode_t op_mode,
  output logic osc_enable,
  output logic synth_enable,
  output logic rx_enable,
  output logic pullup_enable,
  output rxc_pkg::rxc_cfg_t cfg
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic dem_s1, dem_s2;
  logic [1:0] strap_s1, strap_s2;

  always_ff @(posedge core_clk) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_s3 <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_s3 <= sda_s2;
    dem_s1 <= demod_data;
    dem_s2 <= dem_s1;
    strap_s1 <= band_strap;
    strap_s2 <= strap_s1;
  end

  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire scl_hi = scl_s2 & scl_s3;
  wire start_det = ~sda_s2 & sda_s3 & scl_hi;
  wire stop_det = sda_s2 & ~sda_s3 & scl_hi;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] regs [rxc_pkg::NUM_REGS];
  logic [rxc_pkg::NUM_REGS-1:0] ptr_hit;
  logic [7:0] ptr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [7:0] wr_data;
  logic [rxc_pkg::NUM_REGS-1:0][7:0] preset;
  logic auto_load;
  logic leave_cfg;

  for (genvar i = 0; i < rxc_pkg::NUM_REGS; i++) begin : g_hit
    assign ptr_hit[i] = (ptr == rxc_pkg::REG_ADDR[i]);
  end

  // Unmapped pointer reads as zero
  always_comb begin
    rd_data = 8'h00;
    for (int i = 0; i < rxc_pkg::NUM_REGS; i++) begin
      rd_data = rd_data | (ptr_hit[i] ? regs[i] : 8'h00);
    end
  end

  wire exit_req = regs[rxc_pkg::IDX_EXIT][rxc_pkg::EXIT_BIT];
  wire strap_ok = !(strap_s2 == rxc_pkg::STRAP_VDD && !FOUR_BAND);

  // Channel preset applied on automatic entry into receive
  always_comb begin
    preset = rxc_pkg::REG_RST;
    unique case (strap_s2)
      rxc_pkg::STRAP_GND: begin
        preset[rxc_pkg::IDX_OM] = {1'b0, rxc_pkg::BAND_315, 5'h00};
        preset[rxc_pkg::IDX_SX1] = {1'b0, rxc_pkg::INT_315};
        preset[rxc_pkg::IDX_SX2] = rxc_pkg::FRAC_315[7:0];
        preset[rxc_pkg::IDX_SX3] = rxc_pkg::FRAC_315[15:8];
        preset[rxc_pkg::IDX_SX4][3:0] = rxc_pkg::FRAC_315[19:16];
      end
      rxc_pkg::STRAP_VDD: begin
        preset[rxc_pkg::IDX_OM] = {1'b0, rxc_pkg::BAND_868, 5'h00};
        preset[rxc_pkg::IDX_SX1] = {1'b0, INT_868};
        preset[rxc_pkg::IDX_SX2] = FRAC_868[7:0];
        preset[rxc_pkg::IDX_SX3] = FRAC_868[15:8];
        preset[rxc_pkg::IDX_SX4][3:0] = FRAC_868[19:16];
        preset[rxc_pkg::IDX_TS1] = rxc_pkg::TS1_868;
        preset[rxc_pkg::IDX_TS3] = rxc_pkg::TS3_868;
        preset[rxc_pkg::IDX_TS4] = rxc_pkg::TS4_868;
      end
      default: begin
        preset[rxc_pkg::IDX_OM] = {1'b0, rxc_pkg::BAND_433, 5'h00};
      end
    endcase
  end

  // Contents survive sleep: only reset, the strap preset, the slave and the exit-bit clear on leaving configuration change them
  for (genvar i = 0; i < rxc_pkg::NUM_REGS; i++) begin : g_reg
    wire [7:0] mask = rxc_pkg::REG_WMASK[i];
    wire [7:0] merged = (regs[i] & ~mask) | (wr_data & mask);
    wire clr_exit = (i == rxc_pkg::IDX_EXIT) && leave_cfg;
    always_ff @(posedge core_clk) begin
      if (srst) begin
        regs[i] <= rxc_pkg::REG_RST[i];
      end else if (auto_load) begin
        regs[i] <= preset[i];
      end else if (wr_en && ptr_hit[i]) begin
        regs[i] <= merged;
      end else if (clr_exit) begin
        regs[i] <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Operating mode sequencer
  // ----------------------------------------------------------------
  rxc_pkg::rxc_mode_t mode, next_mode;
  logic [rxc_pkg::TIMER_W-1:0] timer, next_timer;
  logic wake_pend, next_wake_pend;

  wire auto_done = timer == rxc_pkg::TIMER_W'(AUTO_RX_CYCLES - 1);
  wire entry_done = timer == rxc_pkg::TIMER_W'(CFG_ENTRY_CYCLES - 1);
  wire tmo_done = timer == rxc_pkg::TIMER_W'(CFG_TIMEOUT_CYCLES - 1);

  always_comb begin
    next_mode = mode;
    next_timer = timer + 1'b1;
    next_wake_pend = wake_pend;
    leave_cfg = 1'b0;
    unique case (mode)
      rxc_pkg::MODE_OFF: begin
        if (auto_done) begin
          next_timer = '0;
          // receive only if the clock pin is sensed low and the strap is allowed, else sleep
          if (!scl_s2 && strap_ok) begin
            next_mode = rxc_pkg::MODE_RX;
          end else begin
            next_mode = rxc_pkg::MODE_SLEEP;
          end
        end
      end
      rxc_pkg::MODE_SLEEP: begin
        if (!wake_pend) begin
          next_timer = '0;
        end
        if (wake_pend && entry_done) begin
          next_mode = rxc_pkg::MODE_CFG;
          next_wake_pend = 1'b0;
          next_timer = '0;
        end else if (!wake_pend && scl_fall && !sda_s2) begin
          next_wake_pend = 1'b1;
        end else if (!wake_pend && scl_fall) begin
          next_mode = rxc_pkg::MODE_RX;
        end
      end
      rxc_pkg::MODE_RX: begin
        next_timer = '0;
      end
      rxc_pkg::MODE_CFG: begin
        if (!scl_s2) begin
          next_timer = '0;
        end
        if ((stop_det && exit_req) || (scl_s2 && tmo_done)) begin
          next_mode = rxc_pkg::MODE_SLEEP;
          next_timer = '0;
          leave_cfg = 1'b1;
        end
      end
      default: begin
        next_mode = rxc_pkg::MODE_OFF;
        next_timer = '0;
      end
    endcase
  end

  assign auto_load = (mode == rxc_pkg::MODE_OFF) &&
                     (next_mode == rxc_pkg::MODE_RX);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode <= rxc_pkg::MODE_OFF;
      timer <= '0;
      wake_pend <= 1'b0;
    end else begin
      mode <= next_mode;
      timer <= next_timer;
      wake_pend <= next_wake_pend;
    end
  end

  // ----------------------------------------------------------------
  // I2C slave, active only in configuration state
  // ----------------------------------------------------------------
  rxc_pkg::rxc_i2c_t i2c_st, next_i2c_st;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] next_ptr;
  logic ack_ph, next_ack_ph;
  logic drv_low, next_drv_low;

  wire addr_match = shreg[7:1] == SLAVE_ADDR;
  wire byte_done = bit_cnt == 4'h8;

  always_comb begin
    next_i2c_st = i2c_st;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_ack_ph = ack_ph;
    next_drv_low = drv_low;
    wr_en = 1'b0;
    wr_data = shreg;
    if (mode != rxc_pkg::MODE_CFG) begin
      next_i2c_st = rxc_pkg::I2C_IDLE;
      next_ack_ph = 1'b0;
      next_drv_low = 1'b0;
    end else if (start_det) begin
      next_i2c_st = rxc_pkg::I2C_ADDR;
      next_bit_cnt = 4'h0;
      next_ack_ph = 1'b0;
      next_drv_low = 1'b0;
    end else if (stop_det) begin
      next_i2c_st = rxc_pkg::I2C_IDLE;
      next_drv_low = 1'b0;
    end else if (scl_rise && i2c_st != rxc_pkg::I2C_IDLE) begin
      if (!ack_ph) begin
        next_shreg = {shreg[6:0], sda_s2};
        next_bit_cnt = bit_cnt + 1'b1;
      end else if (i2c_st == rxc_pkg::I2C_RD && sda_s2) begin
        next_i2c_st = rxc_pkg::I2C_IDLE;
      end
    end else if (scl_fall && i2c_st != rxc_pkg::I2C_IDLE) begin
      if (ack_ph) begin
        next_ack_ph = 1'b0;
        next_bit_cnt = 4'h0;
        next_drv_low = 1'b0;
        if (i2c_st == rxc_pkg::I2C_RD) begin
          next_shreg = rd_data;
          next_ptr = ptr + 1'b1;
          next_drv_low = ~rd_data[7];
        end
      end else if (byte_done) begin
        next_ack_ph = 1'b1;
        next_drv_low = 1'b1;
        unique case (i2c_st)
          rxc_pkg::I2C_ADDR: begin
            if (addr_match) begin
              next_i2c_st = shreg[0] ? rxc_pkg::I2C_RD : rxc_pkg::I2C_PTR;
            end else begin
              next_i2c_st = rxc_pkg::I2C_IDLE;
              next_ack_ph = 1'b0;
              next_drv_low = 1'b0;
            end
          end
          rxc_pkg::I2C_PTR: begin
            next_ptr = shreg;
            next_i2c_st = rxc_pkg::I2C_WR;
          end
          rxc_pkg::I2C_WR: begin
            wr_en = 1'b1;
            next_ptr = ptr + 1'b1;
          end
          rxc_pkg::I2C_RD: begin
            next_drv_low = 1'b0;
          end
          rxc_pkg::I2C_IDLE: begin
            next_ack_ph = 1'b0;
            next_drv_low = 1'b0;
          end
        endcase
      end else if (i2c_st == rxc_pkg::I2C_RD) begin
        next_drv_low = ~shreg[7];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      i2c_st <= rxc_pkg::I2C_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      ack_ph <= 1'b0;
      drv_low <= 1'b0;
    end else begin
      i2c_st <= next_i2c_st;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      ack_ph <= next_ack_ph;
      drv_low <= next_drv_low;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire nx_rx = next_mode == rxc_pkg::MODE_RX;
  wire nx_cfg = next_mode == rxc_pkg::MODE_CFG;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      op_mode <= rxc_pkg::MODE_OFF;
      osc_enable <= 1'b0;
      synth_enable <= 1'b0;
      rx_enable <= 1'b0;
      pullup_enable <= 1'b1;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      op_mode <= next_mode;
      osc_enable <= nx_rx | nx_cfg;
      synth_enable <= nx_rx;
      rx_enable <= nx_rx;
      pullup_enable <= ~nx_rx;
      sda_out <= nx_rx & dem_s2;
      sda_oe <= nx_rx | (nx_cfg & next_drv_low);
    end
  end

  // Field view of the register flops for the analog side
  assign cfg.band_sel = regs[rxc_pkg::IDX_OM][rxc_pkg::BAND_LSB +: 2];
  assign cfg.int_code = regs[rxc_pkg::IDX_SX1][6:0];
  assign cfg.frac_code = {regs[rxc_pkg::IDX_SX4][rxc_pkg::FRAC_HI_W-1:0],
    regs[rxc_pkg::IDX_SX3], regs[rxc_pkg::IDX_SX2]};
  assign cfg.tuning = {regs[10], regs[9], regs[8], regs[7], regs[2],
    regs[0]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [rxc_pkg::TIMER_W-1:0] up_cnt;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      up_cnt <= '0;
    end else if (up_cnt != '1) begin
      up_cnt <= up_cnt + 1'b1;
    end
  end

  AST_SLEEP_QUIET: assert property (@(posedge core_clk) disable iff (srst)
    op_mode == rxc_pkg::MODE_SLEEP |-> !osc_enable && !rx_enable && !synth_enable)
    else $error("oscillator or receiver running in sleep");
  AST_RX_DATA: assert property (@(posedge core_clk) disable iff (srst)
    mode == rxc_pkg::MODE_RX && $past(mode) == rxc_pkg::MODE_RX
    |=> sda_oe && sda_out == $past(dem_s2))
    else $error("demodulated data not on data pin");
  AST_EXIT_CLEARS: assert property (@(posedge core_clk) disable iff (srst)
    $fell(mode == rxc_pkg::MODE_CFG) |-> mode == rxc_pkg::MODE_SLEEP && !exit_req)
    else $error("exit bit not cleared on leaving configuration");
  AST_AUTO_TIME: assert property (@(posedge core_clk) disable iff (srst)
    mode == rxc_pkg::MODE_RX && $past(mode) == rxc_pkg::MODE_OFF
    |-> up_cnt == rxc_pkg::TIMER_W'(AUTO_RX_CYCLES))
    else $error("auto receive entered at wrong time");
  AST_RX_STAYS: assert property (@(posedge core_clk) disable iff (srst)
    mode == rxc_pkg::MODE_RX |=> mode == rxc_pkg::MODE_RX [*4])
    else $error("receive state left without power loss");
  AST_PULLUP: assert property (@(posedge core_clk) disable iff (srst)
    pullup_enable != (op_mode == rxc_pkg::MODE_RX))
    else $error("pull-up state does not match mode");
  AST_START_ADDR: assert property (@(posedge core_clk) disable iff (srst)
    mode == rxc_pkg::MODE_CFG && next_mode == rxc_pkg::MODE_CFG && start_det
    |=> i2c_st == rxc_pkg::I2C_ADDR && bit_cnt == 4'h0)
    else $error("start not followed by address phase");
  AST_ADDR_ACK: assert property (@(posedge core_clk) disable iff (srst)
    mode == rxc_pkg::MODE_CFG && i2c_st == rxc_pkg::I2C_ADDR && scl_fall &&
    byte_done && addr_match && !ack_ph && !start_det && !stop_det
    |=> sda_oe && !sda_out)
    else $error("address byte not acknowledged");
  AST_CFG_ENTRY: assert property (@(posedge core_clk) disable iff (srst)
    $rose(mode == rxc_pkg::MODE_CFG) |-> $past(wake_pend)
    && $past(timer) == rxc_pkg::TIMER_W'(CFG_ENTRY_CYCLES - 1))
    else $error("configuration entered without the entry delay");
  AST_TIMEOUT: assert property (@(posedge core_clk) disable iff (srst)
    mode == rxc_pkg::MODE_CFG |-> timer < rxc_pkg::TIMER_W'(CFG_TIMEOUT_CYCLES))
    else $error("configuration outlived clock-high timeout");
  AST_RESERVED: assert property (@(posedge core_clk) disable iff (srst)
    (regs[rxc_pkg::IDX_OM] & ~rxc_pkg::REG_WMASK[rxc_pkg::IDX_OM]) == 8'h00)
    else $error("reserved mode register bits changed");

endmodule : rxc_top

// >>> tb/rxc_host.sv
// I2C master model of the host controller on the two serial lines
`timescale 1ns/1ps
module rxc_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam realtime H = 62.5;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Level held on the clock pin by the board or host outside frames
  task automatic pin(input logic lvl);
    scl = lvl;
  endtask : pin

  // Clock falls with data low for configuration, data high for receive
  task automatic wake(input logic to_rx);
    sda_low = ~to_rx;
    #(H) scl = 1'b0;
  endtask : wake

  task automatic start_cond();
    sda_low = 1'b0;
    #(H) scl = 1'b1;
    #(H) sda_low = 1'b1;
    #(H) scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    sda_low = 1'b1;
    #(H) scl = 1'b1;
    #(H) sda_low = 1'b0;
    #(H);
  endtask : stop_cond

  // Data only moves while the clock is low, so no false START or STOP
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #(H/2) sda_low = ~b[i];
      #(H/2) scl = 1'b1;
      #(H) scl = 1'b0;
    end
    #(H/2) sda_low = 1'b0;
    #(H/2) scl = 1'b1;
    #(H/2) ack = (sda === 1'b0);
    #(H/2) scl = 1'b0;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #(H/2) sda_low = 1'b0;
      #(H/2) scl = 1'b1;
      #(H/2) b[i] = sda;
      #(H/2) scl = 1'b0;
    end
    #(H/2) sda_low = ~last;
    #(H/2) scl = 1'b1;
    #(H) scl = 1'b0;
  endtask : recv_byte
endmodule : rxc_host

// >>> tb/tb_rxc_top.sv
// Self-checking bench for the receiver mode control block
`timescale 1ns/1ps
module tb_rxc_top;
  localparam int AUTO = 200;
  localparam int ENTRY = 50;
  localparam int TMO = 300;
  localparam logic [6:0] ADDR = 7'h50;
  logic core_clk, srst, demod_data, sda_out, sda_oe, osc_enable;
  logic synth_enable, rx_enable, pullup_enable, scl, sda_low, sda, ack;
  logic [1:0] band_strap;
  rxc_pkg::rxc_mode_t op_mode;
  rxc_pkg::rxc_cfg_t cfg;
  int fail_count = 0;
  int n_compared = 0;

  // Wire follows sda_out while sda_oe is set, else the board pull-up holds it high unless the host pulls it low
  assign sda = sda_oe ? sda_out : ~sda_low;

  rxc_top #(.AUTO_RX_CYCLES(AUTO), .CFG_ENTRY_CYCLES(ENTRY),
    .CFG_TIMEOUT_CYCLES(TMO), .SLAVE_ADDR(ADDR)) dut (
    .core_clk(core_clk), .srst(srst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .band_strap(band_strap),
    .demod_data(demod_data), .op_mode(op_mode), .osc_enable(osc_enable),
    .synth_enable(synth_enable), .rx_enable(rx_enable),
    .pullup_enable(pullup_enable), .cfg(cfg));

  rxc_host host (.scl(scl), .sda_low(sda_low), .sda(sda));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check_val(input logic [31:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic check_mode(input rxc_pkg::rxc_mode_t exp);
    check_val(32'(op_mode), 32'(exp), "mode");
  endtask : check_mode

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wait_mode(input rxc_pkg::rxc_mode_t m, input int bound);
    for (int i = 0; i < bound && op_mode !== m; i++) begin
      tick(1);
    end
    check_mode(m);
    if (op_mode !== m) begin
      print_verdict();
    end
  endtask : wait_mode

  task automatic power_up(input logic lvl, input logic [1:0] strap);
    srst = 1'b1;
    band_strap = strap;
    host.pin(lvl);
    tick(3);
    check_mode(rxc_pkg::MODE_OFF);
    check_val(32'({pullup_enable, sda_oe}), 32'h2, "reset pins");
    srst = 1'b0;
  endtask : power_up

  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] d [$],
    input logic do_stop);
    host.start_cond();
    host.send_byte({ADDR, 1'b0}, ack);
    check_val(32'(ack), 32'h1, "addr ack");
    host.send_byte(ptr, ack);
    foreach (d[i]) begin
      host.send_byte(d[i], ack);
      check_val(32'(ack), 32'h1, "data ack");
    end
    if (do_stop) begin
      host.stop_cond();
    end
  endtask : reg_write

  task automatic reg_read(input logic [7:0] ptr, input logic [7:0] e [$]);
    logic [7:0] b;
    host.start_cond();
    host.send_byte({ADDR, 1'b0}, ack);
    host.send_byte(ptr, ack);
    host.start_cond();
    host.send_byte({ADDR, 1'b1}, ack);
    check_val(32'(ack), 32'h1, "reread ack");
    foreach (e[i]) begin
      host.recv_byte(i == e.size() - 1, b);
      check_val(32'(b), 32'(e[i]), "read");
    end
    host.stop_cond();
  endtask : reg_read

  task automatic enter_cfg();
    host.wake(1'b0);
    tick(ENTRY - 10);
    check_mode(rxc_pkg::MODE_SLEEP);
    wait_mode(rxc_pkg::MODE_CFG, 30);
  endtask : enter_cfg

  logic [31:0] exp_band [3] = '{32'(rxc_pkg::BAND_315),
    32'(rxc_pkg::BAND_433), 32'(rxc_pkg::BAND_868)};
  logic [31:0] exp_int [3] = '{32'(rxc_pkg::INT_315), 32'h2b, 32'h36};
  logic [31:0] exp_frac [3] = '{32'(rxc_pkg::FRAC_315), 32'h5_f3b7, 32'h0};

  initial begin
    srst = 1'b1;
    demod_data = 1'b0;
    band_strap = rxc_pkg::STRAP_FLOAT;
    power_up(1'b1, rxc_pkg::STRAP_FLOAT);
    tick(AUTO + 10);
    check_mode(rxc_pkg::MODE_SLEEP);
    check_val(32'({osc_enable, rx_enable}), 32'h0, "sleep");
    enter_cfg();
    check_val(32'({osc_enable, synth_enable}), 32'h2, "cfg");
    reg_read(8'h10, {8'h00, 8'hb5, 8'h2b, 8'hb7, 8'hf3, 8'h65, 8'h00});
    reg_write(8'h12, {8'hff, 8'h11, 8'h22, 8'h33, 8'hff}, 1'b1);
    check_val(32'(cfg.int_code), 32'h7f, "int");
    check_val(32'(cfg.frac_code), 32'h3_2211, "frac");
    reg_read(8'h12, {8'h7f, 8'h11, 8'h22, 8'h63});
    reg_write(8'h10, {8'hff}, 1'b1);
    reg_write(8'h11, {8'hb6}, 1'b1);
    check_val(32'(cfg.band_sel), 32'h3, "band");
    check_val(32'(cfg.tuning[1]), 32'hb6, "tuning");
    reg_read(8'h10, {8'h60});
    host.start_cond();
    host.send_byte({ADDR ^ 7'h01, 1'b0}, ack);
    check_val(32'(ack), 32'h0, "foreign addr");
    host.stop_cond();
    reg_write(8'h42, {8'h01}, 1'b0);
    tick(20);
    check_mode(rxc_pkg::MODE_CFG);
    host.stop_cond();
    wait_mode(rxc_pkg::MODE_SLEEP, 20);
    check_val(32'(cfg.int_code), 32'h7f, "retained");
    $display("test config done");
    enter_cfg();
    reg_read(8'h42, {8'h00});
    tick(TMO - 60);
    check_mode(rxc_pkg::MODE_CFG);
    wait_mode(rxc_pkg::MODE_SLEEP, 100);
    $display("test exit done");
    host.wake(1'b1);
    wait_mode(rxc_pkg::MODE_RX, 20);
    check_val(32'({synth_enable, rx_enable, pullup_enable, sda_oe}),
      32'hd, "rx pins");
    for (int v = 0; v < 4; v++) begin
      demod_data = v[0];
      tick(4);
      check_val(32'(sda_out), 32'(v[0]), "demod");
    end
    // A full wake sequence must leave receive untouched
    host.pin(1'b1);
    tick(10);
    host.wake(1'b0);
    tick(ENTRY + 20);
    check_mode(rxc_pkg::MODE_RX);
    $display("test sniff done");
    for (int s = 0; s < 3; s++) begin
      power_up(1'b0, 2'(s));
      tick(AUTO - 5);
      check_mode(rxc_pkg::MODE_OFF);
      wait_mode(rxc_pkg::MODE_RX, 20);
      check_val(32'(cfg.band_sel), exp_band[s], "strap band");
      check_val(32'(cfg.int_code), exp_int[s], "strap int");
      check_val(32'(cfg.frac_code), exp_frac[s], "strap frac");
    end
    check_val(32'(cfg.tuning[3]), 32'(rxc_pkg::TS3_868), "strap ts");
    $display("test auto done");
    print_verdict();
  end
endmodule : tb_rxc_top
